// ===== cs_decoder_defs.svh
// Purpose: Named constants of the chip-select area decoder
// Assumes: Included by bare name
// Notes: Register indices are word indices; byte address is four times the index
`ifndef CS_DECODER_DEFS_SVH
`define CS_DECODER_DEFS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_AREA0_START 8'hc8
`define IDX_AREA0_MASK 8'hc9
`define IDX_AREA1_START 8'hca
`define IDX_AREA1_MASK 8'hcb
`define IDX_AREA2_START 8'hcc
`define IDX_AREA2_MASK 8'hcd
`define IDX_AREA3_START 8'hce
`define IDX_AREA3_MASK 8'hcf
`define IDX_BUS_CTL_FIRST 8'hc0
`define IDX_DEFAULT_CTL 8'hc4
`define IDX_PORT6_FUNC 8'hc5
`define IDX_PORT6_DATA 8'hc6
`define IDX_STATUS 8'hc7
`define IDX_LSB 2
`define IDX_MSB 9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AREA_REG_RST 8'hff
`define CTL_RST_OFF 8'h00
`define CTL_RST_AREA2 8'h80
`define PORT6_FUNC_RST 4'h0
`define PORT6_DATA_RST 4'hf

// ----------------------------------------
// Bus control fields
// ----------------------------------------
`define CTL_EN_BIT 7
`define CTL_WAVE_BIT 4
`define CTL_WIDTH_BIT 3
`define CTL_WAITPIN_BIT 2
`define CTL_WAIT_HI 1
`define CTL_WAIT_LO 0

// ----------------------------------------
// Address fields
// ----------------------------------------
`define BASE_HI 23
`define BASE_LO 16
`define AREA_DEFAULT 3'h4

`endif

// ===== cs_decoder_pkg.sv
// Purpose: Types of the chip-select area decoder
// Assumes: Nothing
// Notes: Codes written out
package cs_decoder_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_ACCESS = 2'b10
   } cycle_state_t;

   typedef enum logic [1:0] {
      KIND_AREA0 = 2'b00,
      KIND_AREA1 = 2'b01,
      KIND_WIDE = 2'b10
   } mask_kind_t;

endpackage

// ===== area_match.sv
// Purpose: One area comparator: start and mask against the bus address
// Assumes: Address is 24 bits
// Notes: Purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "cs_decoder_defs.svh"

module area_match
   import cs_decoder_pkg::*;
#(
   parameter mask_kind_t KIND = KIND_WIDE
) (
   input wire logic [23:0] addr,
   input wire logic [7:0] start_val,
   input wire logic [7:0] mask_val,
   input wire logic enable,
   output logic hit
);

   logic [23:0] ignore;
   logic [23:0] base;

   // ----------------------------------------
   // Mask expansion
   // ----------------------------------------
   always_comb begin
      ignore = 24'h000000;
      case (KIND)
         KIND_AREA0: begin
            ignore[20:15] = mask_val[7:2];
            ignore[14:9] = {6{mask_val[1]}};
            ignore[8] = mask_val[0];
            ignore[7:0] = 8'hff;
         end
         KIND_AREA1: begin
            ignore[21:16] = mask_val[7:2];
            ignore[15:9] = {7{mask_val[1]}};
            ignore[8] = mask_val[0];
            ignore[7:0] = 8'hff;
         end
         default: begin
            ignore[22:15] = mask_val;
            ignore[14:0] = 15'h7fff;
         end
      endcase
   end

   // ----------------------------------------
   // Compare
   // ----------------------------------------
   assign base = {start_val, 16'h0000};
   // Bits above the maskable range always compare
   assign hit = enable && (((addr ^ base) & ~ignore) == 24'h000000);

endmodule // area_match

`default_nettype wire

// ===== chip_select_area_decoder.sv
// Purpose: Chip-select and wait controller for four address areas
// Assumes: APB slave on clk; CPU cycle request on clk
// Notes: Zero-wait APB; selects and pins registered
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cs_decoder_defs.svh"

module chip_select_area_decoder
   import cs_decoder_pkg::*;
#(
   parameter int PADDR_WIDTH = 12
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_cycle_req,
   input wire logic [23:0] cpu_addr,
   input wire logic wait_req_n,
   input wire logic bank_select_a_mmu_n,
   input wire logic bank_select_b_mmu_n,
   input wire logic bank_select_c_mmu_n,
   output logic [3:0] area_select_n,
   output logic [3:0] port6_pin,
   output logic bank_select_a_n,
   output logic bank_select_b_n,
   output logic bank_select_c_n,
   output logic cycle_bus_16bit,
   output logic cycle_busy,
   output logic cycle_done
);

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (PADDR_WIDTH < `IDX_MSB + 1) begin : g_bad_width
      $error("PADDR_WIDTH too small for register map");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] start_reg [4];
   logic [7:0] start_next [4];
   logic [7:0] mask_reg [4];
   logic [7:0] mask_next [4];
   logic [7:0] ctl_reg [5];
   logic [7:0] ctl_next [5];
   logic [3:0] port6_func_reg;
   logic [3:0] port6_func_next;
   logic [3:0] port6_data_reg;
   logic [3:0] port6_data_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [3:0] hit;
   logic [2:0] area_pick;
   logic [7:0] idx;
   logic mapped;
   logic wr_en;
   logic [2:0] wait_sync_reg;
   logic wait_level_reg;
   logic wait_level_next;
   logic [2:0] bank_reg;
   cycle_state_t state_reg;
   cycle_state_t state_next;
   logic [1:0] wait_cnt_reg;
   logic [1:0] wait_cnt_next;
   logic [2:0] cur_area_reg;
   logic [2:0] cur_area_next;
   logic [7:0] cur_ctl_reg;
   logic [7:0] cur_ctl_next;
   logic [3:0] sel_n_reg;
   logic [3:0] sel_n_next;
   logic [3:0] pin_reg;
   logic [3:0] pin_next;
   logic width_reg;
   logic width_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;
   logic done_next;
   logic [2:0] last_area_reg;
   logic [2:0] last_area_next;

   // ----------------------------------------
   // Area comparators
   // ----------------------------------------
   genvar gi;
   for (gi = 0; gi < 4; gi++) begin : g_area
      localparam mask_kind_t KIND = (gi == 0) ? KIND_AREA0 : ((gi == 1) ? KIND_AREA1 : KIND_WIDE);
      area_match #(
         .KIND(KIND)
      ) u_match (
         .addr(cpu_addr),
         .start_val(start_reg[gi]),
         .mask_val(mask_reg[gi]),
         .enable(ctl_reg[gi][`CTL_EN_BIT]),
         .hit(hit[gi])
      );
   end

   // Lowest area number wins on overlap
   always_comb begin
      if (hit[0]) begin
         area_pick = 3'h0;
      end else if (hit[1]) begin
         area_pick = 3'h1;
      end else if (hit[2]) begin
         area_pick = 3'h2;
      end else if (hit[3]) begin
         area_pick = 3'h3;
      end else begin
         area_pick = `AREA_DEFAULT;
      end
   end

   // ----------------------------------------
   // Register file and APB
   // ----------------------------------------
   assign idx = paddr[`IDX_MSB:`IDX_LSB];
   assign wr_en = psel && penable && pready_reg && pwrite && pstrb[0];

   always_comb begin
      mapped = 1'b0;
      prdata_next = 32'h00000000;
      for (int n = 0; n < 4; n++) begin
         if (idx == (`IDX_AREA0_START + 8'(2 * n))) begin
            mapped = 1'b1;
            prdata_next[7:0] = start_reg[n];
         end
         if (idx == (`IDX_AREA0_MASK + 8'(2 * n))) begin
            mapped = 1'b1;
            prdata_next[7:0] = mask_reg[n];
         end
      end
      for (int n = 0; n < 5; n++) begin
         if (idx == (`IDX_BUS_CTL_FIRST + 8'(n))) begin
            mapped = 1'b1;
            prdata_next[7:0] = ctl_reg[n];
         end
      end
      if (idx == `IDX_PORT6_FUNC) begin
         mapped = 1'b1;
         prdata_next[3:0] = port6_func_reg;
      end
      if (idx == `IDX_PORT6_DATA) begin
         mapped = 1'b1;
         prdata_next[3:0] = port6_data_reg;
      end
      if (idx == `IDX_STATUS) begin
         mapped = 1'b1;
         prdata_next[3:0] = {busy_reg, last_area_reg};
      end
      if (paddr[`IDX_LSB-1:0] != 2'b00) begin
         mapped = 1'b0;
      end
      if (paddr[PADDR_WIDTH-1:`IDX_LSB] != (PADDR_WIDTH - `IDX_LSB)'(idx)) begin
         mapped = 1'b0;
      end
      if (!mapped || pwrite) begin
         prdata_next = 32'h00000000;
      end
      pready_next = psel && !penable;
      pslverr_next = psel && !penable && !mapped;
      if (!(psel && !penable)) begin
         prdata_next = prdata_reg;
         pslverr_next = 1'b0;
      end
      start_next = start_reg;
      mask_next = mask_reg;
      ctl_next = ctl_reg;
      port6_func_next = port6_func_reg;
      port6_data_next = port6_data_reg;
      if (wr_en && !pslverr_reg) begin
         for (int n = 0; n < 4; n++) begin
            if (idx == (`IDX_AREA0_START + 8'(2 * n))) begin
               start_next[n] = pwdata[7:0];
            end
            if (idx == (`IDX_AREA0_MASK + 8'(2 * n))) begin
               mask_next[n] = pwdata[7:0];
            end
         end
         for (int n = 0; n < 5; n++) begin
            if (idx == (`IDX_BUS_CTL_FIRST + 8'(n))) begin
               ctl_next[n] = pwdata[7:0];
            end
         end
         if (idx == `IDX_PORT6_FUNC) begin
            port6_func_next = pwdata[3:0];
         end
         if (idx == `IDX_PORT6_DATA) begin
            port6_data_next = pwdata[3:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int n = 0; n < 4; n++) begin
            start_reg[n] <= `AREA_REG_RST;
            mask_reg[n] <= `AREA_REG_RST;
         end
         for (int n = 0; n < 5; n++) begin
            ctl_reg[n] <= (n == 2) ? `CTL_RST_AREA2 : `CTL_RST_OFF;
         end
         port6_func_reg <= `PORT6_FUNC_RST;
         port6_data_reg <= `PORT6_DATA_RST;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         start_reg <= start_next;
         mask_reg <= mask_next;
         ctl_reg <= ctl_next;
         port6_func_reg <= port6_func_next;
         port6_data_reg <= port6_data_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ----------------------------------------
   // Wait request synchroniser and bank selects
   // ----------------------------------------
   always_comb begin
      wait_level_next = wait_level_reg;
      if (wait_sync_reg[1] == wait_sync_reg[2]) begin
         wait_level_next = wait_sync_reg[2];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wait_sync_reg <= 3'b111;
         wait_level_reg <= 1'b1;
         bank_reg <= 3'b111;
      end else begin
         wait_sync_reg <= {wait_sync_reg[1:0], wait_req_n};
         wait_level_reg <= wait_level_next;
         bank_reg <= {bank_select_c_mmu_n, bank_select_b_mmu_n, bank_select_a_mmu_n};
      end
   end

   // ----------------------------------------
   // Bus cycle sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      wait_cnt_next = wait_cnt_reg;
      cur_area_next = cur_area_reg;
      cur_ctl_next = cur_ctl_reg;
      sel_n_next = sel_n_reg;
      width_next = width_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      last_area_next = last_area_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cpu_cycle_req) begin
               cur_area_next = area_pick;
               cur_ctl_next = ctl_reg[area_pick];
               wait_cnt_next = ctl_reg[area_pick][`CTL_WAIT_HI:`CTL_WAIT_LO];
               width_next = ctl_reg[area_pick][`CTL_WIDTH_BIT];
               last_area_next = area_pick;
               busy_next = 1'b1;
               if (ctl_reg[area_pick][`CTL_WAVE_BIT]) begin
                  state_next = ST_LEAD;
               end else begin
                  state_next = ST_ACCESS;
                  if (area_pick != `AREA_DEFAULT) begin
                     sel_n_next[area_pick[1:0]] = 1'b0;
                  end
               end
            end
         end
         ST_LEAD: begin
            state_next = ST_ACCESS;
            if (cur_area_reg != `AREA_DEFAULT) begin
               sel_n_next[cur_area_reg[1:0]] = 1'b0;
            end
         end
         ST_ACCESS: begin
            if (wait_cnt_reg != 2'b00) begin
               wait_cnt_next = wait_cnt_reg - 2'b01;
            end else if (!(cur_ctl_reg[`CTL_WAITPIN_BIT] && !wait_level_next)) begin
               state_next = ST_IDLE;
               sel_n_next = 4'hf;
               busy_next = 1'b0;
               done_next = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
            sel_n_next = 4'hf;
            busy_next = 1'b0;
         end
      endcase
      for (int n = 0; n < 4; n++) begin
         pin_next[n] = port6_func_reg[n] ? sel_n_next[n] : port6_data_reg[n];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         wait_cnt_reg <= 2'b00;
         cur_area_reg <= `AREA_DEFAULT;
         cur_ctl_reg <= `CTL_RST_OFF;
         sel_n_reg <= 4'hf;
         pin_reg <= `PORT6_DATA_RST;
         width_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         last_area_reg <= `AREA_DEFAULT;
      end else begin
         state_reg <= state_next;
         wait_cnt_reg <= wait_cnt_next;
         cur_area_reg <= cur_area_next;
         cur_ctl_reg <= cur_ctl_next;
         sel_n_reg <= sel_n_next;
         pin_reg <= pin_next;
         width_reg <= width_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         last_area_reg <= last_area_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign area_select_n = sel_n_reg;
   assign port6_pin = pin_reg;
   assign bank_select_a_n = bank_reg[0];
   assign bank_select_b_n = bank_reg[1];
   assign bank_select_c_n = bank_reg[2];
   assign cycle_bus_16bit = width_reg;
   assign cycle_busy = busy_reg;
   assign cycle_done = done_reg;

endmodule // chip_select_area_decoder

`default_nettype wire

// ===== ext_memory_model.sv
// Purpose: External memory that stretches cycles through the wait request
// Assumes: Watches one active-low area select
// Notes: Line idles high as if pulled up
`timescale 1ns/10ps
`default_nettype none

module ext_memory_model (
   input wire logic clk,
   input wire logic select_n,
   input wire logic [3:0] slow,
   output logic wait_req_n
);
   int cnt;

   // ----------------------------------------
   // Wait request while selected
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (select_n) begin
         cnt <= 0;
      end else if (cnt < 15) begin
         cnt <= cnt + 1;
      end
   end

   assign wait_req_n = !(!select_n && cnt < int'(slow));
endmodule // ext_memory_model

`default_nettype wire

// ===== cs_decoder_asserts.sv
// Purpose: Port checks of the chip-select area decoder
// Assumes: Bound to the decoder top module
// Notes: Single clock domain
`timescale 1ns/10ps
`default_nettype none

module cs_decoder_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic cpu_cycle_req,
   input wire logic [3:0] area_select_n,
   input wire logic cycle_busy,
   input wire logic cycle_done,
   input wire logic cycle_bus_16bit,
   input wire logic bank_select_a_mmu_n,
   input wire logic bank_select_b_mmu_n,
   input wire logic bank_select_c_mmu_n,
   input wire logic bank_select_a_n,
   input wire logic bank_select_b_n,
   input wire logic bank_select_c_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_setup_ready; psel && !penable |=> pready; endproperty
   a_setup_ready: assert property (p_setup_ready)
      else $error("no ready after setup");
   property p_ready_access; pready |-> psel && penable; endproperty
   a_ready_access: assert property (p_ready_access)
      else $error("ready outside access");
   property p_take_cycle; cpu_cycle_req && !cycle_busy |=> cycle_busy; endproperty
   a_take_cycle: assert property (p_take_cycle)
      else $error("cycle not started");
   property p_idle_quiet; !cycle_busy |-> area_select_n == 4'hf; endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("select outside cycle");
   property p_done_ends; cycle_done |-> !cycle_busy && $past(cycle_busy); endproperty
   a_done_ends: assert property (p_done_ends)
      else $error("done without cycle");
   property p_done_pulse; cycle_done |=> !cycle_done; endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done too long");
   property p_width_hold; cycle_busy && $past(cycle_busy) |-> $stable(cycle_bus_16bit); endproperty
   a_width_hold: assert property (p_width_hold)
      else $error("width changed in cycle");
   property p_one_area; $onehot0(~area_select_n); endproperty
   a_one_area: assert property (p_one_area)
      else $error("several selects low");
   property p_bank_pass;
      !$past(sys_rst) |-> {bank_select_a_n, bank_select_b_n, bank_select_c_n} ==
         $past({bank_select_a_mmu_n, bank_select_b_mmu_n, bank_select_c_mmu_n});
   endproperty
   a_bank_pass: assert property (p_bank_pass)
      else $error("bank select altered");
endmodule // cs_decoder_checker

`default_nettype wire

// ===== chip_select_area_decoder_tb.sv
// Purpose: Self-checking bench of the chip-select area decoder
// Assumes: Register model and area model kept here
// Notes: Seeded random areas, addresses and controls
`timescale 1ns/10ps
`default_nettype none

module chip_select_area_decoder_tb;
   import cs_decoder_pkg::*;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, cpu_cycle_req, wait_req_n;
   logic bus16, busy, done;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, area_select_n, port6_pin, slow, sel, pin, fn, st, dat;
   logic [2:0] mmu_n, mmu_prev, bank_n;
   logic [23:0] a;
   logic [7:0] regs [0:7];
   logic [7:0] ctl [0:4];
   logic err;
   int fails, n_compared, e, c, n;

   chip_select_area_decoder chip_select_area_decoder_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_cycle_req(cpu_cycle_req),
      .cpu_addr(a), .wait_req_n(wait_req_n), .bank_select_a_mmu_n(mmu_n[0]),
      .bank_select_b_mmu_n(mmu_n[1]), .bank_select_c_mmu_n(mmu_n[2]), .area_select_n(area_select_n),
      .port6_pin(port6_pin), .bank_select_a_n(bank_n[0]), .bank_select_b_n(bank_n[1]),
      .bank_select_c_n(bank_n[2]), .cycle_bus_16bit(bus16), .cycle_busy(busy), .cycle_done(done));
   ext_memory_model ext_memory_model_i (.clk(clk), .select_n(area_select_n[3]), .slow(slow),
      .wait_req_n(wait_req_n));

   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      mmu_prev <= mmu_n;
      mmu_n <= 3'($urandom);
   end

   // ----------------------------------------
   // Model and tasks
   // ----------------------------------------
   function int exp_area(logic [23:0] ad);
      logic [23:0] ign;
      logic [7:0] m;
      for (int i = 0; i < 4; i++) begin
         m = regs[2*i+1];
         case (i)
            0: ign = {3'h0, m[7:2], {6{m[1]}}, m[0], 8'hff};
            1: ign = {2'h0, m[7:2], {7{m[1]}}, m[0], 8'hff};
            default: ign = {1'b0, m, 15'h7fff};
         endcase
         if (ctl[i][7] && ((ad ^ {regs[2*i], 16'h0}) & ~ign) == 24'h0) return i;
      end
      return 4;
   endfunction

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task cyc(input logic [23:0] ad);
      n = 0;
      sel = 4'hf;
      pin = 4'hf;
      @(posedge clk);
      cpu_cycle_req <= 1;
      a <= ad;
      @(posedge clk);
      cpu_cycle_req <= 0;
      do begin
         @(posedge clk);
         n++;
         sel &= area_select_n;
         pin &= port6_pin;
      end while (done !== 1'b1 && n < 60);
   endtask

   task check_regs;
      for (int i = 0; i < 8; i++) begin
         apb(0, 8'hc8 + 8'(i), 8'h0, 4'hf);
         chk(rd, {24'h0, regs[i]});
      end
   endtask

   task do_reset;
      sys_rst <= 1;
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      foreach (regs[i]) regs[i] = 8'hff;
      foreach (ctl[i]) ctl[i] = 8'h0;
      ctl[2] = 8'h80;
   endtask

   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(40 * 40000);
      fails++;
      end_of_test();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(1));
      {sys_rst, psel, penable, pwrite, cpu_cycle_req, paddr, pwdata, pstrb, a, slow} = '0;
      fails = 0;
      n_compared = 0;
      do_reset();
      check_regs();
      apb(1, 8'h10, 8'h55, 4'hf);
      chk({31'h0, err}, 32'h1);
      for (int p = 0; p < 5; p++) begin
         for (int i = 0; i < 8; i++) begin
            st = 4'($urandom);
            apb(1, 8'hc8 + 8'(i), 8'($urandom), st);
            if (st[0]) regs[i] = pwdata[7:0];
         end
         check_regs();
         for (int i = 0; i < 5; i++) begin
            ctl[i] = 8'($urandom) & (i < 4 ? 8'h9b : 8'h0b);
            if (i == 3 && p == 4) ctl[i] = ctl[i] | 8'h87;
            apb(1, 8'hc0 + 8'(i), ctl[i], 4'hf);
         end
         fn = p == 0 ? 4'h0 : 4'($urandom);
         apb(1, 8'hc5, {4'h0, fn}, 4'hf);
         dat = 4'($urandom);
         apb(1, 8'hc6, {4'h0, dat}, 4'hf);
         slow <= 4'(p * 3);
         for (int k = 0; k < 24; k++) begin
            e = 32'($urandom) % 4;
            cyc(k % 4 == 3 ? 24'($urandom) : {regs[2*e], 16'($urandom)});
            e = exp_area(a);
            c = e < 4 ? e : 4;
            chk(sel, 4'(e < 4 ? ~(4'b1 << e) : 4'hf));
            chk(pin, 4'(((e < 4 ? ~(4'b1 << e) : 4'hf) | ~fn) & (dat | fn)));
            chk(bus16, ctl[c][3]);
            chk({29'h0, bank_n}, {29'h0, mmu_prev});
            if (!ctl[c][2]) chk(n, 2 + ctl[c][1:0] + (c < 4 ? ctl[c][4] : 0));
            else chk(n > 2 + ctl[c][1:0] + ctl[c][4] && n < 60, 1);
         end
         apb(0, 8'hc7, 8'h0, 4'hf);
         chk(rd, {28'h0, 1'b0, 3'(c)});
      end
      do_reset();
      check_regs();
      end_of_test();
   end
endmodule // chip_select_area_decoder_tb

bind chip_select_area_decoder cs_decoder_checker cs_decoder_checker_i (.clk(clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pready(pready), .cpu_cycle_req(cpu_cycle_req),
   .area_select_n(area_select_n), .cycle_busy(cycle_busy), .cycle_done(cycle_done),
   .cycle_bus_16bit(cycle_bus_16bit), .bank_select_a_mmu_n(bank_select_a_mmu_n),
   .bank_select_b_mmu_n(bank_select_b_mmu_n), .bank_select_c_mmu_n(bank_select_c_mmu_n),
   .bank_select_a_n(bank_select_a_n), .bank_select_b_n(bank_select_b_n), .bank_select_c_n(bank_select_c_n));

`default_nettype wire
